// file: sarseq_pkg.sv
package sarseq_pkg;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE       = 16'hFF80;  // converter_mode_reg
  localparam logic [15:0] ADDR_CHANNEL    = 16'hFF81;  // channel_select_reg
  localparam logic [15:0] ADDR_WIDE_LO    = 16'hFF18;  // wide_conversion_result, low byte
  localparam logic [15:0] ADDR_WIDE_HI    = 16'hFF19;  // wide_conversion_result, high byte
  localparam logic [15:0] ADDR_UPPER      = 16'hFF1A;  // upper_conversion_result
  localparam logic [15:0] ADDR_DIRECTION  = 16'hFF22;  // port2_direction
  localparam logic [15:0] ADDR_FUNC_SEL   = 16'hFF84;  // port2_function_select

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RUN_BIT    = 7;   // conversion_run
  localparam int CMP_EN_BIT = 0;   // comparator_enable
  localparam int RES_BITS   = 10;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [1:0] CHANNEL_RST   = 2'h0;
  localparam logic [3:0] DIRECTION_RST = 4'h0;
  localparam logic [3:0] FUNC_SEL_RST  = 4'h0;
  localparam logic [3:0] DIR_UPPER_RD  = 4'hF;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SAMPLE_NS     = 1500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYC      = 4;  // Settling cycles per approximation step
  localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYC - 1);
  localparam logic [7:0] STEP_LAST   = 8'(STEP_CYC - 1);

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SARSEQ_IDLE   = 4'b0001,
    SARSEQ_SAMPLE = 4'b0010,
    SARSEQ_STEP   = 4'b0100,
    SARSEQ_DONE   = 4'b1000
  } sarseq_state_t;

endpackage

// file: sarseq_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one level
module sarseq_sync2 (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sarseq_sync_t;

  sarseq_sync_t st_q;
  sarseq_sync_t st_d;

  // First stage feeds only the second
  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;

endmodule

// file: sar_adc_sequencer.sv
`timescale 1ns/1ps
module sar_adc_sequencer (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        comparator_out,
  output logic      [9:0]  approximation_shift_reg,
  output logic             sample_enable,
  output logic      [1:0]  analog_channel,
  output logic             comparator_enable,
  output logic             conversion_done_irq,
  output logic      [3:0]  pin_output_enable,
  output logic      [3:0]  pin_analog_connect
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Every flip-flop of the block outside the comparator synchroniser lives in this one struct.
  // Control fields: sequencer state and the four software registers.
  // Datapath fields: trial code, bit pointer and the shared timer.
  // Result fields: wide and upper copies plus a deferred-load slot.
  // Output fields: registered copies so each port leaves a flop.
  typedef struct packed {
    sarseq_pkg::sarseq_state_t fsm;
    logic [7:0]                mode;
    logic [1:0]                channel;
    logic [3:0]                direction;
    logic [3:0]                func_sel;
    logic [9:0]                sar;
    logic [3:0]                bit_idx;
    logic [7:0]                timer;
    logic [9:0]                wide;
    logic [7:0]                upper;
    logic                      load_pend;
    logic [9:0]                pend_val;
    logic                      irq;
    logic [7:0]                rdata;
    logic                      sample_en;
    logic [3:0]                oe;
    logic [3:0]                ana;
  } sarseq_st_t;

  sarseq_st_t st_q;
  sarseq_st_t st_d;

  // Comparator answer after the two-flop crossing
  logic       cmp_sync;

  // ------------------------------------------------------------
  // Comparator input crossing
  // ------------------------------------------------------------
  // The comparator decides on its own timing, so its answer is
  // synchronised before the sequencer looks at it.
  // This adds two cycles of lag; each step waits long enough
  // that the sampled answer belongs to the current trial code.
  sarseq_sync2 u_cmp_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (comparator_out),
    .dout    (cmp_sync)
  );

  // Decoded bus events for this cycle
  logic wr_mode;
  logic wr_chan;
  logic rd_result;
  logic run;

  // Bus decode
  // Mode and channel writes both abort a running conversion.
  // A result read is any read of the three result addresses;
  // reads elsewhere never delay a result load.
  always_comb begin
    wr_mode   = bus_wr && (bus_addr == sarseq_pkg::ADDR_MODE);
    wr_chan   = bus_wr && (bus_addr == sarseq_pkg::ADDR_CHANNEL);
    rd_result = bus_rd && ((bus_addr == sarseq_pkg::ADDR_WIDE_LO) ||
                           (bus_addr == sarseq_pkg::ADDR_WIDE_HI) ||
                           (bus_addr == sarseq_pkg::ADDR_UPPER));
    run       = st_q.mode[sarseq_pkg::RUN_BIT];
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // One conversion, counted from the start edge:
  //   one cycle in idle while the run bit takes effect,
  //   the sampling window with the switch closed,
  //   ten steps of settle-then-compare, most significant bit first,
  //   one done cycle that hands the result over and restarts sampling.
  // The done pulse leaves the flop together with the loaded result unless a result read in the done cycle parks it.
  // Writes and clears of the run bit are applied last so they win
  // over whatever the sequencer wanted in the same cycle.
  always_comb begin
    st_d     = st_q;
    st_d.irq = 1'b0;

    // Register writes
    if (wr_mode) begin
      st_d.mode = bus_wdata;
    end
    if (wr_chan) begin
      st_d.channel = bus_wdata[1:0];
    end
    if (bus_wr && (bus_addr == sarseq_pkg::ADDR_DIRECTION)) begin
      st_d.direction = bus_wdata[3:0];
    end
    if (bus_wr && (bus_addr == sarseq_pkg::ADDR_FUNC_SEL)) begin
      st_d.func_sel = bus_wdata[3:0];
    end

    // Deferred result load after a colliding read
    // The bus keeps the old word for the whole read; the new one
    // lands in the first cycle with no result read.
    if (st_q.load_pend && !rd_result) begin
      st_d.wide      = st_q.pend_val;
      st_d.upper     = st_q.pend_val[9:2];
      st_d.load_pend = 1'b0;
    end

    // Sequencer
    // The timer is shared: it counts the sampling window first and
    // then the settling cycles of each approximation step.
    case (st_q.fsm)
      sarseq_pkg::SARSEQ_IDLE: begin
        // Wait here for the run bit; a mode or channel write this cycle delays the start
        st_d.sample_en = 1'b0;
        if (run && !wr_mode && !wr_chan) begin
          st_d.fsm       = sarseq_pkg::SARSEQ_SAMPLE;
          st_d.timer     = '0;
          st_d.sample_en = 1'b1;
        end
      end
      sarseq_pkg::SARSEQ_SAMPLE: begin
        // Opening the switch and the first trial code share one edge
        if (st_q.timer == sarseq_pkg::SAMPLE_LAST) begin
          st_d.sample_en = 1'b0;
          st_d.fsm       = sarseq_pkg::SARSEQ_STEP;
          st_d.sar       = 10'h200;
          st_d.bit_idx   = 4'h9;
          st_d.timer     = '0;
        end else begin
          st_d.timer = st_q.timer + 8'h01;
        end
      end
      sarseq_pkg::SARSEQ_STEP: begin
        if (st_q.timer == sarseq_pkg::STEP_LAST) begin
          st_d.timer = '0;
          // Keep the trial bit when input is at or above the tap
          // The next lower bit is set as the new trial on the same edge
          st_d.sar[st_q.bit_idx] = cmp_sync;
          if (st_q.bit_idx == 4'h0) begin
            st_d.fsm = sarseq_pkg::SARSEQ_DONE;
          end else begin
            st_d.bit_idx = st_q.bit_idx - 4'h1;
            st_d.sar[st_q.bit_idx - 4'h1] = 1'b1;
          end
        end else begin
          st_d.timer = st_q.timer + 8'h01;
        end
      end
      sarseq_pkg::SARSEQ_DONE: begin
        // A result read in this cycle parks the word instead
        st_d.irq = 1'b1;
        if (rd_result) begin
          st_d.load_pend = 1'b1;
          st_d.pend_val  = st_q.sar;
        end else begin
          st_d.wide  = st_q.sar;
          st_d.upper = st_q.sar[9:2];
        end
        st_d.fsm       = sarseq_pkg::SARSEQ_SAMPLE;
        st_d.timer     = '0;
        st_d.sample_en = 1'b1;
      end
      default: begin
        st_d.fsm = sarseq_pkg::SARSEQ_IDLE;
      end
    endcase

    // Mode or channel write aborts; a write in the done cycle wins over the load
    // Software may have changed the input or the timing under a running
    // conversion, so the half-built code is dropped and no pulse is sent.
    // Idle then restarts on its own if the run bit is still set.
    if (wr_mode || wr_chan) begin
      st_d.irq       = 1'b0;
      st_d.sample_en = 1'b0;
      st_d.fsm       = sarseq_pkg::SARSEQ_IDLE;
      if (st_q.fsm == sarseq_pkg::SARSEQ_DONE) begin
        st_d.wide      = st_q.wide;
        st_d.upper     = st_q.upper;
        st_d.load_pend = st_q.load_pend && rd_result;
      end
    end
    // Run cleared stops immediately
    // The trial code is left as it was; the result registers keep
    // the last complete conversion.
    if (!run && (st_q.fsm != sarseq_pkg::SARSEQ_IDLE)) begin
      st_d.fsm       = sarseq_pkg::SARSEQ_IDLE;
      st_d.sample_en = 1'b0;
      st_d.irq       = 1'b0;
    end

    // Pin control: analog select overrides port drive
    // Built from the next register values so the pins follow a
    // write on the same edge that stores it.
    st_d.ana = st_d.func_sel;
    st_d.oe  = ~st_d.direction & ~st_d.func_sel;

    // Read data
    // Data stands for the one cycle after the strobe and is zero
    // otherwise, so a missed strobe never shows stale data.
    st_d.rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        sarseq_pkg::ADDR_MODE:      st_d.rdata = st_q.mode;
        sarseq_pkg::ADDR_CHANNEL:   st_d.rdata = {6'h00, st_q.channel};
        sarseq_pkg::ADDR_WIDE_LO:   st_d.rdata = st_q.wide[7:0];
        sarseq_pkg::ADDR_WIDE_HI:   st_d.rdata = {6'h00, st_q.wide[9:8]};
        sarseq_pkg::ADDR_UPPER:     st_d.rdata = st_q.upper;
        sarseq_pkg::ADDR_DIRECTION: st_d.rdata = {sarseq_pkg::DIR_UPPER_RD,
                                                  st_q.direction};
        sarseq_pkg::ADDR_FUNC_SEL:  st_d.rdata = {4'h0, st_q.func_sel};
        default:                    st_d.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Results, approximation and pending words are not cleared by reset
  // The control, pointer, timer, pending-flag and output fields get reset values; the data words hold
  // whatever they last had, which software must treat as undefined.
  // Reset is asynchronous so the pins reach their reset state, all four output-enabled, even with no clock.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.fsm       <= sarseq_pkg::SARSEQ_IDLE;
      st_q.mode      <= sarseq_pkg::MODE_RST;
      st_q.channel   <= sarseq_pkg::CHANNEL_RST;
      st_q.direction <= sarseq_pkg::DIRECTION_RST;
      st_q.func_sel  <= sarseq_pkg::FUNC_SEL_RST;
      st_q.bit_idx   <= 4'h0;
      st_q.timer     <= 8'h00;
      st_q.load_pend <= 1'b0;
      st_q.irq       <= 1'b0;
      st_q.rdata     <= 8'h00;
      st_q.sample_en <= 1'b0;
      st_q.oe        <= 4'hF;
      st_q.ana       <= 4'h0;
    end else begin
      // Result words have no reset value and simply follow their next value
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every port is a plain copy of a state field, so no output
  // glitches while the bus decode settles.
  // The trial code drives the tap selector directly.
  assign bus_rdata               = st_q.rdata;
  assign approximation_shift_reg = st_q.sar;
  assign sample_enable           = st_q.sample_en;
  assign analog_channel          = st_q.channel;
  assign comparator_enable       = st_q.mode[sarseq_pkg::CMP_EN_BIT];
  assign conversion_done_irq     = st_q.irq;
  assign pin_output_enable       = st_q.oe;
  assign pin_analog_connect      = st_q.ana;

endmodule

// file: sarseq_asserts.sv
`timescale 1ns/1ps
module sarseq_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        comparator_out,
  input wire logic [9:0]  approximation_shift_reg,
  input wire logic        sample_enable,
  input wire logic [1:0]  analog_channel,
  input wire logic        comparator_enable,
  input wire logic        conversion_done_irq,
  input wire logic [3:0]  pin_output_enable,
  input wire logic [3:0]  pin_analog_connect
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Hold phase entered by the sequencer itself, not by a write
  sequence hold_start;
    $fell(sample_enable) && !$past(bus_wr);
  endsequence

  irq_pulse_a: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done pulse longer than one cycle");
  idle_rdata_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero without a read");
  pin_block_a: assert property ((pin_output_enable & pin_analog_connect) == 4'h0)
    else $error("analog pin still driven");
  chan_load_a: assert property (bus_wr && bus_addr == sarseq_pkg::ADDR_CHANNEL
    |=> analog_channel == $past(bus_wdata[1:0])) else $error("channel not taken");
  cmp_en_a: assert property (bus_wr && bus_addr == sarseq_pkg::ADDR_MODE
    |=> comparator_enable == $past(bus_wdata[0])) else $error("enable not taken");
  hold_msb_a: assert property (hold_start |-> approximation_shift_reg == 10'h200)
    else $error("first trial code wrong");
  step_len_a: assert property (hold_start |-> ##1 $stable(approximation_shift_reg)[*3]
    ##1 approximation_shift_reg[8]) else $error("second step wrong");
  hold_keep_a: assert property (hold_start |-> (!sample_enable)[*8])
    else $error("sample switch closed during hold");
  done_restart_a: assert property (conversion_done_irq |-> sample_enable)
    else $error("no new sampling at result load");
endmodule

bind sar_adc_sequencer sarseq_asserts u_asserts (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .comparator_out(comparator_out),
  .approximation_shift_reg(approximation_shift_reg), .sample_enable(sample_enable),
  .analog_channel(analog_channel), .comparator_enable(comparator_enable),
  .conversion_done_irq(conversion_done_irq), .pin_output_enable(pin_output_enable),
  .pin_analog_connect(pin_analog_connect));

// file: sarseq_front_model.sv
`timescale 1ns/1ps
module sarseq_front_model (
  input  wire logic        clk_sys,
  input  wire logic [39:0] levels,
  input  wire logic [9:0]  approximation_shift_reg,
  input  wire logic        sample_enable,
  input  wire logic [1:0]  analog_channel,
  input  wire logic        comparator_enable,
  output logic             comparator_out
);
  logic [9:0] held_q;
  logic       noise_q = 1'b0;

  // Track the selected input while sampling, freeze it while holding
  always @(posedge clk_sys) begin
    noise_q <= ~noise_q;
    if (sample_enable) begin
      held_q <= levels[analog_channel*10 +: 10];
    end
  end

  // Ideal comparator on the trial code; a stopped comparator gives junk
  assign comparator_out = comparator_enable ?
                          (held_q >= approximation_shift_reg) : noise_q;
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_rdata;
  logic        cmp_out;
  logic [9:0]  sar;
  logic        sample_en;
  logic [1:0]  chan;
  logic        cmp_en;
  logic        irq;
  logic [3:0]  pin_oe;
  logic [3:0]  pin_an;
  logic [39:0] levels = {10'h155, 10'h2AA, 10'h000, 10'h3FF};
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          irq_count = 0;
  int          n;
  logic [7:0]  d8;
  logic [15:0] d16;
  logic [9:0]  exp_code;

  sar_adc_sequencer u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .comparator_out(cmp_out), .approximation_shift_reg(sar), .sample_enable(sample_en),
    .analog_channel(chan), .comparator_enable(cmp_en), .conversion_done_irq(irq),
    .pin_output_enable(pin_oe), .pin_analog_connect(pin_an));
  sarseq_front_model u_front (.clk_sys(clk_sys), .levels(levels),
    .approximation_shift_reg(sar), .sample_enable(sample_en), .analog_channel(chan),
    .comparator_enable(cmp_en), .comparator_out(cmp_out));

  // ------------------
  // Clock and watchdog
  // ------------------
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (irq === 1'b1) begin
      irq_count++;
    end
    if (cycles == 10000) begin
      miscompares++;
      summarize();
    end
  end

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Byte write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_wr = 1'b0;
  endtask

  // Byte read, data the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask

  // Wide result as two back-to-back byte reads, high byte first
  task automatic rd16(output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    bus_addr = sarseq_pkg::ADDR_WIDE_HI;
    bus_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_addr = sarseq_pkg::ADDR_WIDE_LO;
    d[15:8] = bus_rdata;
    @(posedge clk_sys);
    #1;
    bus_rd = 1'b0;
    d[7:0] = bus_rdata;
  endtask

  // Wait for the next done pulse; n is the cycles waited
  task automatic wait_irq(output int w);
    int c0;
    c0 = irq_count;
    w = 0;
    while (irq_count == c0 && w < 400) begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    chk("done_irq", 16'h0001, 16'(irq_count - c0));
  endtask

  // -----
  // Tests
  // -----
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    chk("pin_oe", 16'h000F, {12'h000, pin_oe});
    chk("pin_an", 16'h0000, {12'h000, pin_an});
    rd(sarseq_pkg::ADDR_CHANNEL, d8);
    chk("channel", 16'h0000, {8'h00, d8});
    rd(sarseq_pkg::ADDR_DIRECTION, d8);
    chk("direction", 16'h00F0, {8'h00, d8});
    rd(sarseq_pkg::ADDR_FUNC_SEL, d8);
    chk("func_sel", 16'h0000, {8'h00, d8});
    $display("Test reset done");
    wr(sarseq_pkg::ADDR_DIRECTION, 8'h05);
    wr(sarseq_pkg::ADDR_FUNC_SEL, 8'h03);
    rd(sarseq_pkg::ADDR_DIRECTION, d8);
    chk("direction", 16'h00F5, {8'h00, d8});
    rd(sarseq_pkg::ADDR_FUNC_SEL, d8);
    chk("func_sel", 16'h0003, {8'h00, d8});
    rd(16'hFF00, d8);
    chk("unmapped", 16'h0000, {8'h00, d8});
    chk("pin_an", 16'h0003, {12'h000, pin_an});
    chk("pin_oe", 16'h0008, {12'h000, pin_oe});
    wr(sarseq_pkg::ADDR_DIRECTION, 8'h0F);
    wr(sarseq_pkg::ADDR_FUNC_SEL, 8'h0F);
    chk("pin_an", 16'h000F, {12'h000, pin_an});
    chk("pin_oe", 16'h0000, {12'h000, pin_oe});
    $display("Test pins done");
    wr(sarseq_pkg::ADDR_MODE, 8'h01);
    repeat (100) @(posedge clk_sys);
    wr(sarseq_pkg::ADDR_MODE, 8'h81);
    for (int ch = 0; ch < 4; ch++) begin
      wr(sarseq_pkg::ADDR_CHANNEL, 8'(ch));
      wait_irq(n);
      wait_irq(n);
      wr(sarseq_pkg::ADDR_WIDE_LO, 8'hFF);
      exp_code = levels[ch*10 +: 10];
      rd16(d16);
      chk("wide_result", {6'h00, exp_code}, d16);
      rd(sarseq_pkg::ADDR_UPPER, d8);
      chk("upper_result", {8'h00, exp_code[9:2]}, {8'h00, d8});
    end
    $display("Test conversions done");
    wait_irq(n);
    repeat (50) @(posedge clk_sys);
    wr(sarseq_pkg::ADDR_CHANNEL, 8'h03);
    wait_irq(n);
    chk("restart_len", 16'h0001, 16'(n > 180));
    $display("Test abort done");
    wait_irq(n);
    wr(sarseq_pkg::ADDR_MODE, 8'h01);
    n = irq_count;
    repeat (400) @(posedge clk_sys);
    chk("stopped", 16'(n), 16'(irq_count));
    chk("cmp_en", 16'h0001, {15'h0000, cmp_en});
    chk("sample_en", 16'h0000, {15'h0000, sample_en});
    $display("Test stop done");
    repeat (2) @(posedge clk_sys);
    wr(sarseq_pkg::ADDR_MODE, 8'h81);
    wait_irq(n);
    rd16(d16);
    chk("wide_result", {6'h00, levels[39:30]}, d16);
    $display("Test restart done");
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    chk("sample_en", 16'h0000, {15'h0000, sample_en});
    chk("cmp_en", 16'h0000, {15'h0000, cmp_en});
    chk("channel", 16'h0000, {14'h0000, chan});
    chk("pin_oe", 16'h000F, {12'h000, pin_oe});
    n = irq_count;
    repeat (250) @(posedge clk_sys);
    chk("no_restart", 16'(n), 16'(irq_count));
    $display("Test reset again done");
    summarize();
  end
endmodule
